// file: shared/psmc_pkg.sv
// Package of constants and types for the power saving mode controller
// Overview of operation
// - Reset starts run mode, clock divided by two
// - Slow enable plus two-bit frequency select
// - Slow mode divides by 4, 8, 16, 32
// - Wait during slow keeps reduced peripheral clock
// - Wait stops CPU, peripherals keep running
// - Wait entry clears interrupt mask bit only
// - Wait left by interrupt or reset, then service
// - Halt op picks halt or active halt
// - Active halt exit waits 4096 CPU cycles
// - Active halt entry clears interrupt mask bit
// - Active halt clocks only oscillator and timebase
// - Active halt never triggers watchdog reset
// - Halt exit restarts oscillator, 4096 cycle delay
// - Halt entry forces interrupt mask to zero
// - Halt stops oscillator and all internal clocks
// - Watchdog halt option decides watchdog reset
// - Wake service pushes flags, sets mask bit
// - Any irqRequest line wakes wait, timebase does not; chosen ones halt
// - Timebase interrupt wakes active halt only
package psmc_pkg;

   localparam int unsigned CLOCK_MHZ        = 100;
   localparam int unsigned WAKE_DELAY_CYC   = 4096;
   localparam int unsigned IRQ_COUNT        = 8;

   localparam logic [7:0] ADDR_CTRL         = 8'h00;
   localparam logic [7:0] ADDR_STATUS       = 8'h04;

   localparam int unsigned CTRL_SLOW_BIT    = 0;
   localparam int unsigned CTRL_SEL_LSB     = 1;
   localparam int unsigned CTRL_OIE_BIT     = 3;
   localparam int unsigned STAT_MODE_LSB    = 0;
   localparam int unsigned STAT_WDGOPT_BIT  = 3;
   localparam int unsigned STAT_STALL_BIT   = 4;
   localparam int unsigned STAT_OSC_BIT     = 5;

   localparam logic        SLOW_RESET       = 1'b0;
   localparam logic [1:0]  SEL_RESET        = 2'h0;
   localparam logic        OIE_RESET        = 1'b0;
   localparam logic [IRQ_COUNT-1:0] HALT_WAKE_MASK = 8'h0f;

   typedef enum logic [2:0]
   {
      MODE_RUN,
      MODE_WAIT,
      MODE_ACTIVE_HALT,
      MODE_HALT,
      MODE_STARTUP
   } psmc_mode_t;

   typedef struct packed
   {
      logic       oscIrqEnable;
      logic [1:0] slowClockSelect;
      logic       slowModeEnable;
   } psmc_ctrl_t;

   typedef struct packed
   {
      logic cpuStall;
      logic maskClear;
      logic serviceStart;
      logic watchdogResetReq;
   } psmc_cpu_t;

   // Oscillator cycles per CPU cycle minus one
   function automatic logic [4:0] psmc_div_last(input logic slowEn, input logic [1:0] sel);
      logic [4:0] r;
      r = 5'h01;
      if (slowEn)
         r = 5'(({27'h0, 5'h04} << sel) - 32'd1);
      return r;
   endfunction

endpackage

// file: verilog/psmc_clk_div.sv
// Oscillator divider producing the CPU and peripheral cycle strobe
`timescale 1ns/1ps
module psmc_clk_div
   import psmc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       reset_n,
   input  wire logic       run,
   input  wire logic [4:0] lastCount,
   output wire logic       tick
);

   logic [4:0] count_r;
   logic [4:0] count_nxt;
   wire        atEnd = (count_r >= lastCount);

   // Wraps early if the divide shrinks mid count, so no long stall
   assign count_nxt = (!run || atEnd) ? 5'h00 : 5'(count_r + 5'h01);
   assign tick      = run && atEnd;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= 5'h00;
      else
         count_r <= count_nxt;
   end

endmodule

// file: verilog/psmc_top.sv
// Power saving mode controller: mode sequencing, clock gating, APB registers
`timescale 1ns/1ps
module psmc_top
   import psmc_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_DELAY_CYC,
   parameter int unsigned IRQS        = IRQ_COUNT,
   parameter logic [IRQ_COUNT-1:0] HALT_WAKE = HALT_WAKE_MASK
)
(
   input  wire logic            clock,
   input  wire logic            reset_n,
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   input  wire logic [3:0]      pstrb,
   output wire logic            pready,
   output wire logic            pslverr,
   output logic      [31:0]     prdata,
   input  wire logic            waitForInterruptOp,
   input  wire logic            haltOp,
   input  wire logic [IRQS-1:0] irqRequest,
   input  wire logic            timebaseIrq,
   input  wire logic            watchdogActive,
   input  wire logic            watchdogHaltOption,
   output wire logic            cpuClockTick,
   output wire logic            periphClockTick,
   output wire logic            timebaseClockTick,
   output wire logic            oscillatorEnable,
   output psmc_cpu_t            cpuCtl
);

   psmc_mode_t  mode_r;
   psmc_mode_t  mode_nxt;
   psmc_ctrl_t  ctrl_r;
   psmc_ctrl_t  ctrl_nxt;
   psmc_cpu_t   cpu_nxt;
   logic [12:0] wakeCount_r;
   logic [12:0] wakeCount_nxt;
   logic        wdgOption_r;
   logic        optTaken_r;
   logic [31:0] prdata_nxt;
   logic        tick;

   localparam logic [12:0] WAKE_LAST = 13'(WAKE_CYCLES - 1);

   // APB decode
   wire setupPhase  = psel && !penable;
   wire accessPhase = psel && penable;
   wire hitCtrl     = (paddr == ADDR_CTRL);
   wire hitStatus   = (paddr == ADDR_STATUS);
   wire mapped      = hitCtrl || hitStatus;
   wire ctrlWrite   = accessPhase && pwrite && hitCtrl && pstrb[0];

   // Wake sources per mode
   wire anyIrq      = |irqRequest;
   wire haltIrq     = |(irqRequest & HALT_WAKE[IRQS-1:0]);
   wire activeWake  = haltIrq || timebaseIrq;
   wire fullWake    = haltIrq;
   wire wakeDone    = (wakeCount_r == WAKE_LAST);

   // Halt op picks the mode from the timebase interrupt enable
   wire haltTarget  = ctrl_r.oscIrqEnable;

   // Zero-wait slave; prdata captured in setup so it comes from a flop
   assign pready    = 1'b1;
   assign pslverr   = accessPhase && !mapped;

   // Clock divider for CPU cycles
   psmc_clk_div u_div
   (
      .clock     (clock),
      .reset_n   (reset_n),
      .run       (oscillatorEnable),
      .lastCount (psmc_div_last(ctrl_r.slowModeEnable,
                                ctrl_r.slowClockSelect)),
      .tick      (tick)
   );

   // Oscillator stops only in full halt
   assign oscillatorEnable  = (mode_r != MODE_HALT);
   // CPU clocked only in run; the startup count keeps it stopped
   assign cpuClockTick      = tick && (mode_r == MODE_RUN);
   // Wait keeps peripherals on the same divided strobe, slow or not
   assign periphClockTick   = tick && ((mode_r == MODE_RUN) ||
                                       (mode_r == MODE_WAIT));
   // Timebase keeps counting in active halt and in the wake delay
   assign timebaseClockTick = tick && (mode_r != MODE_HALT);

   // Control register write
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (ctrlWrite)
      begin
         ctrl_nxt.slowModeEnable  = pwdata[CTRL_SLOW_BIT];
         ctrl_nxt.slowClockSelect = pwdata[CTRL_SEL_LSB +: 2];
         ctrl_nxt.oscIrqEnable    = pwdata[CTRL_OIE_BIT];
      end
   end

   // Read data mux
   always_comb
   begin
      prdata_nxt = 32'h0000_0000;
      if (hitCtrl)
      begin
         prdata_nxt[CTRL_SLOW_BIT]     = ctrl_r.slowModeEnable;
         prdata_nxt[CTRL_SEL_LSB +: 2] = ctrl_r.slowClockSelect;
         prdata_nxt[CTRL_OIE_BIT]      = ctrl_r.oscIrqEnable;
      end
      else if (hitStatus)
      begin
         prdata_nxt[STAT_MODE_LSB +: 3] = mode_r;
         prdata_nxt[STAT_WDGOPT_BIT]    = wdgOption_r;
         prdata_nxt[STAT_STALL_BIT]     = cpuCtl.cpuStall;
         prdata_nxt[STAT_OSC_BIT]       = oscillatorEnable;
      end
   end

   // Mode sequencer
   always_comb
   begin
      mode_nxt      = mode_r;
      wakeCount_nxt = wakeCount_r;
      cpu_nxt       = '{cpuStall: 1'b1, maskClear: 1'b0,
                        serviceStart: 1'b0, watchdogResetReq: 1'b0};
      case (mode_r)
         MODE_RUN:
         begin
            cpu_nxt.cpuStall = 1'b0;
            if (haltOp)
            begin
               // Mask cleared so a pending interrupt wakes at once
               cpu_nxt.maskClear = 1'b1;
               cpu_nxt.cpuStall  = 1'b1;
               if (haltTarget)
                  mode_nxt = MODE_ACTIVE_HALT;
               else
               begin
                  mode_nxt = MODE_HALT;
                  // Option clear means halt is not tolerated
                  cpu_nxt.watchdogResetReq = watchdogActive && !wdgOption_r;
               end
            end
            else if (waitForInterruptOp)
            begin
               mode_nxt          = MODE_WAIT;
               cpu_nxt.maskClear = 1'b1;
               cpu_nxt.cpuStall  = 1'b1;
            end
         end
         MODE_WAIT:
         begin
            if (anyIrq)
            begin
               mode_nxt             = MODE_RUN;
               cpu_nxt.serviceStart = 1'b1;
               cpu_nxt.cpuStall     = 1'b0;
            end
         end
         MODE_ACTIVE_HALT:
         begin
            // No watchdog reset request is ever raised here
            cpu_nxt.watchdogResetReq = 1'b0;
            if (activeWake)
            begin
               mode_nxt      = MODE_STARTUP;
               wakeCount_nxt = 13'h0000;
            end
         end
         MODE_HALT:
         begin
            if (fullWake)
            begin
               mode_nxt      = MODE_STARTUP;
               wakeCount_nxt = 13'h0000;
            end
         end
         MODE_STARTUP:
         begin
            // Counts CPU cycles at the current divide
            if (tick)
            begin
               if (wakeDone)
               begin
                  mode_nxt             = MODE_RUN;
                  cpu_nxt.serviceStart = 1'b1;
                  cpu_nxt.cpuStall     = 1'b0;
               end
               else
                  wakeCount_nxt = 13'(wakeCount_r + 13'h0001);
            end
         end
         default:
         begin
            mode_nxt = MODE_RUN;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_r      <= MODE_RUN;
         wakeCount_r <= 13'h0000;
         cpuCtl      <= '{cpuStall: 1'b0, maskClear: 1'b0,
                          serviceStart: 1'b0, watchdogResetReq: 1'b0};
      end
      else
      begin
         mode_r      <= mode_nxt;
         wakeCount_r <= wakeCount_nxt;
         cpuCtl      <= cpu_nxt;
      end
   end

   // Register file; slow mode off at reset gives divide by two
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_r <= '{oscIrqEnable: OIE_RESET, slowClockSelect: SEL_RESET,
                     slowModeEnable: SLOW_RESET};
         prdata <= 32'h0000_0000;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         if (setupPhase)
            prdata <= prdata_nxt;
      end
   end

   // Nonvolatile option caught once after reset release
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wdgOption_r <= 1'b0;
         optTaken_r  <= 1'b0;
      end
      else if (!optTaken_r)
      begin
         wdgOption_r <= watchdogHaltOption;
         optTaken_r  <= 1'b1;
      end
   end

endmodule

// file: verif/psmc_top_asserts.sv
// Port assertions for the power mode controller
`timescale 1ns/1ps
module psmc_top_asserts
   import psmc_pkg::*;
(
   input wire logic      clock,
   input wire logic      reset_n,
   input wire logic      haltOp,
   input wire logic      waitForInterruptOp,
   input wire logic      watchdogHaltOption,
   input wire logic      cpuClockTick,
   input wire logic      periphClockTick,
   input wire logic      timebaseClockTick,
   input wire logic      oscillatorEnable,
   input wire psmc_cpu_t cpuCtl
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   property p_run_tick;
      cpuClockTick |-> !cpuCtl.cpuStall && periphClockTick;
   endproperty
   a_run_tick: assert property (p_run_tick) else $error("cpu tick while stalled");
   property p_div_min;
      cpuClockTick |=> !cpuClockTick;
   endproperty
   a_div_min: assert property (p_div_min) else $error("cpu tick too fast");
   property p_entry;
      (haltOp || waitForInterruptOp) && !cpuCtl.cpuStall |=> cpuCtl.cpuStall && cpuCtl.maskClear;
   endproperty
   a_entry: assert property (p_entry) else $error("op not taken");
   property p_mask;
      $rose(cpuCtl.cpuStall) |-> cpuCtl.maskClear ##1 !cpuCtl.maskClear;
   endproperty
   a_mask: assert property (p_mask) else $error("mask clear pulse wrong");
   property p_wake;
      $fell(cpuCtl.cpuStall) |-> cpuCtl.serviceStart;
   endproperty
   a_wake: assert property (p_wake) else $error("wake without service");
   property p_halt_off;
      !oscillatorEnable |-> !timebaseClockTick && !periphClockTick && cpuCtl.cpuStall;
   endproperty
   a_halt_off: assert property (p_halt_off) else $error("clock in halt");
   property p_startup;
      $rose(oscillatorEnable) |-> cpuCtl.cpuStall [*8];
   endproperty
   a_startup: assert property (p_startup) else $error("startup too short");
   property p_wdg;
      cpuCtl.watchdogResetReq |-> !oscillatorEnable && !watchdogHaltOption;
   endproperty
   a_wdg: assert property (p_wdg) else $error("bad watchdog reset");
endmodule

bind psmc_top psmc_top_asserts u_chk (.clock(clock), .reset_n(reset_n), .haltOp(haltOp),
   .waitForInterruptOp(waitForInterruptOp), .watchdogHaltOption(watchdogHaltOption),
   .cpuClockTick(cpuClockTick), .periphClockTick(periphClockTick),
   .timebaseClockTick(timebaseClockTick), .oscillatorEnable(oscillatorEnable), .cpuCtl(cpuCtl));

// file: verif/psmc_cpu_model.sv
// Core model: issues power ops and tracks the interrupt mask bit
`timescale 1ns/1ps
module psmc_cpu_model
   import psmc_pkg::*;
(
   input  wire logic      clock,
   input  wire logic      reset_n,
   input  wire logic      doWait,
   input  wire logic      doHalt,
   input  wire psmc_cpu_t cpuCtl,
   output wire logic      waitForInterruptOp,
   output wire logic      haltOp,
   output logic           maskBit_r
);
   // A stalled core fetches nothing, so it issues no ops
   assign waitForInterruptOp = doWait && !cpuCtl.cpuStall;
   assign haltOp = doHalt && !cpuCtl.cpuStall;
   always_ff @(posedge clock or negedge reset_n)
      if (!reset_n)
         maskBit_r <= 1'b1;
      else if (cpuCtl.maskClear)
         maskBit_r <= 1'b0;
      else if (cpuCtl.serviceStart)
         maskBit_r <= 1'b1;
endmodule

// file: verif/psmc_top_bench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
module psmc_top_bench
   import psmc_pkg::*;
;
   logic        clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, probe = 0;
   logic        doWait = 0, doHalt = 0, tbIrq = 0, wdgOn = 0, wdgOpt = 0;
   logic [7:0]  paddr = 0, irq = 0;
   logic [31:0] pwdata = 0, r;
   logic [3:0]  pstrb = 0;
   logic        pready, pslverr, wOp, hOp, cTick, pTick, tTick, osc, maskBit;
   logic [31:0] prdata;
   psmc_cpu_t   cpuCtl;
   logic [32:0] rdQ[$];
   int          loQ[$], hiQ[$], gapQ[$];
   int          error_cnt = 0, cmp_count = 0, cyc = 0, tWake = 0, lastTick = 0, lat, lo, hi;
   int          cpuCnt = 0, perCnt = 0, tbCnt = 0, wdgCnt = 0, mark, markP;
   psmc_top #(.WAKE_CYCLES(8)) dut (.clock(clock), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .waitForInterruptOp(wOp),
      .haltOp(hOp), .irqRequest(irq), .timebaseIrq(tbIrq), .watchdogActive(wdgOn),
      .watchdogHaltOption(wdgOpt), .cpuClockTick(cTick), .periphClockTick(pTick),
      .timebaseClockTick(tTick), .oscillatorEnable(osc), .cpuCtl(cpuCtl));
   psmc_cpu_model cpu (.clock(clock), .reset_n(reset_n), .doWait(doWait), .doHalt(doHalt),
      .cpuCtl(cpuCtl), .waitForInterruptOp(wOp), .haltOp(hOp), .maskBit_r(maskBit));
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         error_cnt++;
         tally_and_finish;
      end
   end
   // Running tallies of clock strobes and watchdog requests
   always @(posedge clock)
   begin
      if (cTick === 1'b1)
         cpuCnt <= cpuCnt + 1;
      if (pTick === 1'b1)
         perCnt <= perCnt + 1;
      if (tTick === 1'b1)
         tbCnt <= tbCnt + 1;
      if (cpuCtl.watchdogResetReq === 1'b1)
         wdgCnt <= wdgCnt + 1;
   end
   always @(posedge clock)
      if (psel && penable && !pwrite)
         check({pslverr, prdata}, rdQ.pop_front());
   always @(posedge clock)
      if (pTick)
      begin
         if (probe)
         begin
            check(33'(cyc - lastTick), 33'(gapQ.pop_front()));
            probe <= 1'b0;
         end
         lastTick = cyc;
      end
   always @(posedge clock)
      if (cpuCtl.serviceStart === 1'b1)
      begin
         lat = cyc - tWake;
         lo = loQ.pop_front();
         hi = hiQ.pop_front();
         check(33'(maskBit), 33'h0);
         check(33'(lat >= lo && lat <= hi), 33'h1);
      end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      rdQ.push_back(e);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask
   task gap(input int g);
      int n;
      gapQ.push_back(g);
      // Let a divider change settle before timing a tick gap
      repeat (70) @(posedge clock);
      probe <= 1'b1;
      n = 0;
      do
         @(posedge clock);
      while (probe && ++n < 100);
   endtask
   task op(input logic h);
      @(posedge clock);
      doHalt <= h;
      doWait <= !h;
      @(posedge clock);
      doHalt <= 1'b0;
      doWait <= 1'b0;
   endtask
   task svc(input int l, input int h);
      int n;
      loQ.push_back(l);
      hiQ.push_back(h);
      tWake = cyc;
      n = 0;
      do
         @(posedge clock);
      while (cpuCtl.serviceStart !== 1'b1 && ++n < 300);
      irq <= 8'h0;
      tbIrq <= 1'b0;
   endtask
   task wake(input logic [7:0] i, input logic t, input int l, input int h);
      @(posedge clock);
      irq <= i;
      tbIrq <= t;
      svc(l, h);
   endtask
   initial
   begin
      void'($urandom(32'h2b70));
      r = $urandom();
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_STATUS, 33'h20);
      rd(ADDR_CTRL, 33'h0);
      rd(8'h08, {1'b1, 32'h0});
      gap(2);
      for (int s = 0; s < 4; s++)
      begin
         apb(1'b1, ADDR_CTRL, 32'(1 + 2 * s), 4'hf);
         gap(4 << s);
      end
      apb(1'b1, ADDR_CTRL, r, 4'hf);
      apb(1'b1, ADDR_CTRL, ~r, 4'he);
      apb(1'b1, ADDR_STATUS, 32'h0, 4'hf);
      rd(ADDR_CTRL, {29'h0, r[3:0]});
      apb(1'b1, ADDR_CTRL, 32'h3, 4'hf);
      wdgOn <= 1'b1;
      op(1'b0);
      rd(ADDR_STATUS, 33'h31);
      mark = cpuCnt;
      gap(8);
      check(33'(cpuCnt - mark), 33'h0);
      wake(8'h1 << r[6:4], 1'b0, 2, 2);
      apb(1'b1, ADDR_CTRL, 32'h8, 4'hf);
      op(1'b1);
      rd(ADDR_STATUS, 33'h32);
      mark = tbCnt;
      markP = perCnt;
      repeat (10) @(posedge clock);
      check(33'(tbCnt - mark), 33'h5);
      check(33'(perCnt - markP), 33'h0);
      check(33'(wdgCnt), 33'h0);
      wake(8'h0, 1'b1, 15, 22);
      apb(1'b1, ADDR_CTRL, 32'h0, 4'hf);
      op(1'b1);
      rd(ADDR_STATUS, 33'h13);
      check(33'(osc), 33'h0);
      mark = tbCnt;
      irq <= 8'h80;
      tbIrq <= 1'b1;
      repeat (20) @(posedge clock);
      rd(ADDR_STATUS, 33'h13);
      check(33'(tbCnt - mark), 33'h0);
      check(33'(wdgCnt), 33'h1);
      wake(8'h81, 1'b1, 15, 22);
      apb(1'b1, ADDR_CTRL, 32'h8, 4'hf);
      irq <= 8'h02;
      op(1'b1);
      svc(15, 22);
      op(1'b0);
      reset_n <= 1'b0;
      // Option strap only changes while reset holds
      wdgOpt <= 1'b1;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      rd(ADDR_STATUS, 33'h28);
      op(1'b1);
      rd(ADDR_STATUS, 33'h1b);
      wake(8'h01, 1'b0, 15, 22);
      check(33'(wdgCnt), 33'h1);
      repeat (3) @(posedge clock);
      check(33'(rdQ.size() + gapQ.size() + loQ.size()), 33'h0);
      tally_and_finish;
   end
endmodule
